//--- twp_timer.sv
// Delayed one-shot waveform timer with AXI4-Lite register slave
// What this block does
// - Output inactive until wait elapses, then active
// - Counter can stop at period compare match
// - This mode excludes every other timer mode
// - Count on prescaled clocks, oscillator or pin
// - Period is period compare plus one
// - Active width is end minus wait
// - Wait lasts wait compare plus one
// - No trigger: start on run write
// - Trigger and period stop enabled: start on valid edge
// - Run cleared: stop, initial level, hold count
// - Period stop: initial level, optional clear
// - Event on each of three compare matches
// - Event on counter overflow
// - Trigger edge rising, falling or both
// - Counter readable and writable by software
// - Pin roles: trigger in, waveform out
// - Interrupt pin can force output off
// - Buffer register feeds next end point
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module twp_timer import twp_pkg::*; #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [AXI_AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read address and data
  input wire logic arvalid,
  output logic arready,
  input wire logic [AXI_AW-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Pins
  input wire logic trigger_input_pin,
  input wire logic external_count_pin,
  input wire logic fast_onchip_osc_clock,
  input wire logic ext_interrupt_zero_pin,
  output logic waveform_output_pin_o,
  output logic waveform_output_pin_oe,
  // Event pulses: period, end, wait match, overflow
  output logic [3:0] event_pulse
);
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W must lie between 2 and 32");
  end
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  typedef struct packed {
    twp_run_t st;
    logic run_bit;
    logic end_point_buffer_enable;
    logic [2:0] src;
    logic output_initial_level_bit;
    logic clear_on_match;
    logic [1:0] trigger_edge_field;
    logic stop_on_period_match;
    logic cut_en;
    logic [CNT_W-1:0] main_counter;
    logic [CNT_W-1:0] period_compare_reg;
    logic [CNT_W-1:0] end_point_compare_reg;
    logic [CNT_W-1:0] wait_compare_reg;
    logic [CNT_W-1:0] buffered_end_point_reg;
    logic [PRE_W-1:0] pre;
    logic out;
    logic pin;
    logic oe;
    logic [3:0] ev;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [AXI_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } twp_state_t;

  twp_state_t st_ff;
  twp_state_t nxt_st;
  logic tick, pm, em, wm, ovf, trig_hit, need_trig, start_req, cnt_wr, cnt_clr, wr_go, cutoff;
  logic [32:0] rd_w, wr_w;
  logic [31:0] wr_word;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  twp_pin_if trg_if ();
  twp_pin_if ext_if ();
  twp_pin_if osc_if ();
  twp_pin_if cut_if ();
  // channel A pin acts as trigger input
  twp_pin_sync #(.IDLE(1'b0)) u_trg (.aclk(aclk), .aresetn(aresetn), .raw(trigger_input_pin), .pin(trg_if));
  twp_pin_sync #(.IDLE(1'b0)) u_ext (.aclk(aclk), .aresetn(aresetn), .raw(external_count_pin), .pin(ext_if));
  twp_pin_sync #(.IDLE(1'b0)) u_osc (.aclk(aclk), .aresetn(aresetn), .raw(fast_onchip_osc_clock), .pin(osc_if));
  twp_pin_sync #(.IDLE(1'b1)) u_cut (.aclk(aclk), .aresetn(aresetn), .raw(ext_interrupt_zero_pin), .pin(cut_if));

  // ****************************************************************
  // Register read view
  // ****************************************************************
  function automatic logic [32:0] read_word(input logic [AXI_AW-1:0] a, input twp_state_t s);
    logic [31:0] w;
    logic hit;
    w = 32'h0000_0000;
    hit = 1'b1;
    case (a)
      ADDR_MODE: begin
        w[MODE_RUN] = s.run_bit;
        w[MODE_BFD] = s.end_point_buffer_enable;
        // mode fixed, no other mode selectable
        w[MODE_PWM2] = 1'b1;
      end
      ADDR_CTL1: begin
        w[CTL1_SRC_LSB+:3] = s.src;
        w[CTL1_INIT] = s.output_initial_level_bit;
        w[CTL1_CLEAR_ON_MATCH] = s.clear_on_match;
      end
      ADDR_CTL2: begin
        w[CTL2_EDGE_LSB+:2] = s.trigger_edge_field;
        w[CTL2_STOP_ON_PERIOD_MATCH] = s.stop_on_period_match;
        w[CTL2_CUT] = s.cut_en;
      end
      ADDR_COUNT: w[CNT_W-1:0] = s.main_counter;
      ADDR_PERIOD: w[CNT_W-1:0] = s.period_compare_reg;
      ADDR_END: w[CNT_W-1:0] = s.end_point_compare_reg;
      ADDR_WAIT: w[CNT_W-1:0] = s.wait_compare_reg;
      ADDR_BUF: w[CNT_W-1:0] = s.buffered_end_point_reg;
      ADDR_STAT: begin
        w[STAT_OUT] = s.out;
        w[STAT_CNT] = (s.st == ST_COUNT);
        w[STAT_ARM] = (s.st == ST_ARMED);
      end
      default: hit = 1'b0;
    endcase
    return {hit, w};
  endfunction : read_word

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i+:8] = d[8*i+:8];
      end
    end
    return r;
  endfunction : merge

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ev = 4'h0;
    rd_w = read_word(araddr, st_ff);
    wr_w = read_word(st_ff.awaddr, st_ff);
    wr_word = merge(wr_w[31:0], st_ff.wdata, st_ff.wstrb);
    wr_go = st_ff.aw_have & st_ff.w_have & ~st_ff.bvalid;
    start_req = 1'b0;
    cnt_wr = 1'b0;
    cnt_clr = 1'b0;
    // Write channels are taken in either order, then answered together
    if (awvalid && st_ff.awready) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.awaddr = awaddr;
    end
    if (wvalid && st_ff.wready) begin
      nxt_st.w_have = 1'b1;
      nxt_st.wdata = wdata;
      nxt_st.wstrb = wstrb;
    end
    if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (wr_go) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = wr_w[32] ? RESP_OKAY : RESP_SLVERR;
      case (st_ff.awaddr)
        ADDR_MODE: begin
          nxt_st.run_bit = wr_word[MODE_RUN];
          nxt_st.end_point_buffer_enable = wr_word[MODE_BFD];
          start_req = wr_word[MODE_RUN];
        end
        ADDR_CTL1: begin
          nxt_st.src = wr_word[CTL1_SRC_LSB+:3];
          nxt_st.output_initial_level_bit = wr_word[CTL1_INIT];
          nxt_st.clear_on_match = wr_word[CTL1_CLEAR_ON_MATCH];
          nxt_st.oe = 1'b1;
        end
        ADDR_CTL2: begin
          nxt_st.trigger_edge_field = wr_word[CTL2_EDGE_LSB+:2];
          nxt_st.stop_on_period_match = wr_word[CTL2_STOP_ON_PERIOD_MATCH];
          nxt_st.cut_en = wr_word[CTL2_CUT];
        end
        ADDR_COUNT: cnt_wr = 1'b1;
        ADDR_PERIOD: nxt_st.period_compare_reg = wr_word[CNT_W-1:0];
        ADDR_END: nxt_st.end_point_compare_reg = wr_word[CNT_W-1:0];
        ADDR_WAIT: nxt_st.wait_compare_reg = wr_word[CNT_W-1:0];
        ADDR_BUF: nxt_st.buffered_end_point_reg = wr_word[CNT_W-1:0];
        default: ;
      endcase
    end
    nxt_st.awready = ~nxt_st.aw_have;
    nxt_st.wready = ~nxt_st.w_have;
    if (arvalid && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd_w[31:0];
      nxt_st.rresp = rd_w[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
    end
    nxt_st.arready = ~nxt_st.rvalid;

    nxt_st.pre = st_ff.pre + PRE_W'(1);
    case (st_ff.src)
      SRC_F1: tick = 1'b1;
      SRC_F2: tick = (st_ff.pre & DIV2_MASK) == DIV2_MASK;
      SRC_F4: tick = (st_ff.pre & DIV4_MASK) == DIV4_MASK;
      SRC_F8: tick = (st_ff.pre & DIV8_MASK) == DIV8_MASK;
      SRC_F32: tick = (st_ff.pre & DIV32_MASK) == DIV32_MASK;
      SRC_OSC: tick = osc_if.rise;
      SRC_EXT: tick = ext_if.rise;
      default: tick = 1'b0;
    endcase
    trig_hit = (st_ff.trigger_edge_field[EDGE_RISE_BIT] & trg_if.rise) |
               (st_ff.trigger_edge_field[EDGE_FALL_BIT] & trg_if.fall);
    need_trig = (st_ff.trigger_edge_field != EDGE_OFF) & st_ff.stop_on_period_match;
    pm = st_ff.main_counter == st_ff.period_compare_reg;
    em = st_ff.main_counter == st_ff.end_point_compare_reg;
    wm = st_ff.main_counter == st_ff.wait_compare_reg;
    // overflow unless the period match clears or stops the count first
    ovf = (st_ff.main_counter == CNT_MAX) & ~(pm & (st_ff.clear_on_match | st_ff.stop_on_period_match));

    case (st_ff.st)
      ST_STOP: begin
        // start on run write when no trigger needed
        if (start_req) begin
          nxt_st.st = need_trig ? ST_ARMED : ST_COUNT;
        end
      end
      ST_ARMED: begin
        // trigger edge starts counting from zero
        if (trig_hit) begin
          nxt_st.st = ST_COUNT;
          nxt_st.main_counter = '0;
          cnt_clr = 1'b1;
        end
      end
      ST_COUNT: begin
        if (tick) begin
          nxt_st.ev = {ovf, wm, em, pm};
          nxt_st.main_counter = st_ff.main_counter + CNT_W'(1);
          // end match deactivates, wait match activates
          if (em) begin
            nxt_st.out = st_ff.output_initial_level_bit;
          end
          // active after wait plus one ticks
          if (wm) begin
            nxt_st.out = ~st_ff.output_initial_level_bit;
          end
          if (pm) begin
            // buffered end point loads at period
            if (st_ff.end_point_buffer_enable) begin
              nxt_st.end_point_compare_reg = st_ff.buffered_end_point_reg;
            end
            if (st_ff.clear_on_match) begin
              nxt_st.main_counter = '0;
              cnt_clr = 1'b1;
            end
            if (st_ff.stop_on_period_match) begin
              nxt_st.st = need_trig ? ST_ARMED : ST_STOP;
              if (!st_ff.clear_on_match) begin
                nxt_st.main_counter = st_ff.main_counter;
              end
            end
          end
        end
      end
      default: nxt_st.st = ST_STOP;
    endcase
    // software load loses only to a hardware clear
    if (cnt_wr && !cnt_clr) begin
      nxt_st.main_counter = wr_word[CNT_W-1:0];
    end
    // run cleared stops with count held
    if (!nxt_st.run_bit) begin
      nxt_st.st = ST_STOP;
    end
    if (nxt_st.st != ST_COUNT) begin
      nxt_st.out = nxt_st.output_initial_level_bit;
    end
    // low interrupt pin forces the initial level
    cutoff = st_ff.cut_en & ~cut_if.level;
    nxt_st.pin = cutoff ? nxt_st.output_initial_level_bit : nxt_st.out;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign awready = st_ff.awready;
  assign wready = st_ff.wready;
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign arready = st_ff.arready;
  assign rvalid = st_ff.rvalid;
  assign rdata = st_ff.rdata;
  assign rresp = st_ff.rresp;
  assign waveform_output_pin_o = st_ff.pin;
  assign waveform_output_pin_oe = st_ff.oe;
  assign event_pulse = st_ff.ev;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_counting_tick;
    // A register write in the same cycle may legally override the compare action
    tick && st_ff.st == ST_COUNT && st_ff.run_bit && !wr_go;
  endsequence
  sequence s_wait_hit;
    s_counting_tick ##0 wm && !pm;
  endsequence

  a_wait_activates: assert property (s_wait_hit |=> st_ff.out == ~st_ff.output_initial_level_bit)
    else $error("wait match did not activate output");
  a_end_deactivates: assert property (s_counting_tick ##0 em && !wm |=> st_ff.out == st_ff.output_initial_level_bit)
    else $error("end match did not deactivate output");
  a_oneshot_stop: assert property (s_counting_tick ##0 pm && st_ff.stop_on_period_match && st_ff.clear_on_match
    |=> st_ff.st != ST_COUNT && st_ff.main_counter == '0)
    else $error("period stop did not clear and halt");
  a_run_off_idle: assert property (!st_ff.run_bit |-> st_ff.st == ST_STOP && st_ff.out == st_ff.output_initial_level_bit)
    else $error("stopped timer not idle at initial level");
  a_overflow_event: assert property (s_counting_tick ##0 st_ff.main_counter == CNT_MAX && !pm |=> event_pulse[3])
    else $error("overflow event missing");
  a_trigger_start: assert property (st_ff.st == ST_ARMED && trig_hit && st_ff.run_bit
    |=> st_ff.st == ST_COUNT && st_ff.main_counter == '0)
    else $error("trigger did not start count from zero");
  a_armed_holds: assert property (st_ff.st == ST_ARMED && !trig_hit |=> st_ff.st != ST_COUNT)
    else $error("count started without trigger");
  a_count_step: assert property (s_counting_tick ##0 !pm && !cnt_wr
    |=> st_ff.main_counter == CNT_W'($past(st_ff.main_counter) + CNT_W'(1)))
    else $error("counter did not advance by one");
  a_buffer_load: assert property (s_counting_tick ##0 pm && st_ff.end_point_buffer_enable
    |=> st_ff.end_point_compare_reg == $past(st_ff.buffered_end_point_reg))
    else $error("buffered end point not transferred");
  a_repeat_wrap: assert property (s_counting_tick ##0 pm && st_ff.clear_on_match && !st_ff.stop_on_period_match
    |=> st_ff.st == ST_COUNT && st_ff.main_counter == '0)
    else $error("period match did not wrap and continue");
endmodule : twp_timer

//--- twp_pkg.sv
// Constants, register map and enumerations of the delayed one-shot waveform timer
package twp_pkg;
  // ****************************************************************
  // Register bus
  // ****************************************************************
  localparam int AXI_AW = 8;
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTL1 = 8'h04;
  localparam logic [7:0] ADDR_CTL2 = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_PERIOD = 8'h10;
  localparam logic [7:0] ADDR_END = 8'h14;
  localparam logic [7:0] ADDR_WAIT = 8'h18;
  localparam logic [7:0] ADDR_BUF = 8'h1C;
  localparam logic [7:0] ADDR_STAT = 8'h20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int MODE_RUN = 0;
  localparam int MODE_BFD = 1;
  localparam int MODE_PWM2 = 2;
  localparam int CTL1_SRC_LSB = 0;
  localparam int CTL1_INIT = 3;
  localparam int CTL1_CLEAR_ON_MATCH = 4;
  localparam int CTL2_EDGE_LSB = 0;
  localparam int CTL2_STOP_ON_PERIOD_MATCH = 2;
  localparam int CTL2_CUT = 3;
  localparam int STAT_OUT = 0;
  localparam int STAT_CNT = 1;
  localparam int STAT_ARM = 2;
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;
  // ****************************************************************
  // Count source prescaler
  // ****************************************************************
  localparam int PRE_W = 5;
  localparam logic [4:0] DIV2_MASK = 5'h01;
  localparam logic [4:0] DIV4_MASK = 5'h03;
  localparam logic [4:0] DIV8_MASK = 5'h07;
  localparam logic [4:0] DIV32_MASK = 5'h1F;
  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [2:0] {
    SRC_F1 = 3'b000,
    SRC_F2 = 3'b001,
    SRC_F4 = 3'b010,
    SRC_F8 = 3'b011,
    SRC_F32 = 3'b100,
    SRC_OSC = 3'b101,
    SRC_EXT = 3'b110
  } twp_src_t;
  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } twp_edge_t;
  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_ARMED = 2'b01,
    ST_COUNT = 2'b10
  } twp_run_t;
endpackage : twp_pkg

//--- twp_pin_if.sv
// Synchronised pin level and edge pulses passed from a pin synchroniser
`timescale 1ns/1ps
interface twp_pin_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : twp_pin_if

//--- twp_pin_sync.sv
// Three-flop pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module twp_pin_sync import twp_pkg::*; #(
  parameter logic IDLE = 1'b0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Raw pin and clean result
  input wire logic raw,
  twp_pin_if.src pin
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
    logic fall;
  } twp_sync_t;
  localparam twp_sync_t RST = '{s1: IDLE, s2: IDLE, s3: IDLE, level: IDLE, rise: 1'b0, fall: 1'b0};
  twp_sync_t st_ff;
  twp_sync_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = raw;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.rise = 1'b0;
    nxt_st.fall = 1'b0;
    // A change counts only once the two later stages agree
    if (st_ff.s2 == st_ff.s3 && st_ff.s3 != st_ff.level) begin
      nxt_st.level = st_ff.s3;
      nxt_st.rise = st_ff.s3;
      nxt_st.fall = ~st_ff.s3;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin.level = st_ff.level;
  assign pin.rise = st_ff.rise;
  assign pin.fall = st_ff.fall;
endmodule : twp_pin_sync

//--- twp_far.sv
// Far-side model: trigger source, cutoff source and waveform load
`timescale 1ns/1ps
module twp_far (
  // Clock
  input wire logic aclk,
  // Pins driven and watched
  output logic trig,
  output logic cut_n,
  input wire logic wave,
  // Measured shape in clock cycles
  output int hi_len,
  output int per_len,
  output int rises
);
  int hi_cnt;
  int per_cnt;
  logic wave_q;
  initial begin
    trig = 1'b0;
    cut_n = 1'b1;
    wave_q = 1'b0;
  end
  task automatic set_pins(input logic t, input logic c);
    trig <= t;
    cut_n <= c;
  endtask : set_pins
  // Widths run from one edge of the load's input to the next
  always @(posedge aclk) begin
    wave_q <= wave;
    per_cnt <= per_cnt + 1;
    if (wave) hi_cnt <= hi_cnt + 1;
    if (wave && !wave_q) begin
      rises <= rises + 1;
      per_len <= per_cnt;
      per_cnt <= 1;
    end
    if (!wave && wave_q) begin
      hi_len <= hi_cnt;
      hi_cnt <= 0;
    end
  end
endmodule : twp_far

//--- triggered_wait_one_shot_pwm_tb.sv
// Self-checking bench of the delayed one-shot waveform timer
`timescale 1ns/1ps
module triggered_wait_one_shot_pwm_tb;
  import twp_pkg::*;
  typedef struct {
    logic [2:0] src;
    int p;
    int n;
    int m;
    int sc;
  } twp_row_t;
  logic aclk;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic ext_cnt = 1'b0;
  logic osc = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, wave_o, wave_oe, trig, cut_n;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [3:0] ev;
  logic [3:0] ev_seen = 4'h0;
  logic ev_clr = 1'b0;
  int hi_len, per_len, rises, r0;
  int error_cnt = 0;
  int checks_done = 0;
  // Source, wait, end point, period, clocks per tick
  twp_row_t rows [7] = '{'{SRC_F1, 2, 5, 9, 1}, '{SRC_F2, 1, 4, 7, 2}, '{SRC_F4, 0, 3, 5, 4},
    '{SRC_F8, 2, 3, 6, 8}, '{SRC_F32, 1, 3, 4, 32}, '{SRC_OSC, 2, 6, 8, 4}, '{SRC_EXT, 1, 2, 5, 8}};
  twp_timer u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
    .bvalid(bvalid), .bready(1'b1), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(1'b1), .rdata(rdata), .rresp(rresp),
    .trigger_input_pin(trig), .external_count_pin(ext_cnt), .fast_onchip_osc_clock(osc),
    .ext_interrupt_zero_pin(cut_n), .waveform_output_pin_o(wave_o),
    .waveform_output_pin_oe(wave_oe), .event_pulse(ev));
  twp_far u_far (.aclk(aclk), .trig(trig), .cut_n(cut_n), .wave(wave_o & wave_oe),
    .hi_len(hi_len), .per_len(per_len), .rises(rises));
  // ****************
  // Clocks and bus tasks
  // ****************
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // Phase chosen so that oscillator and count pin never move at a rising clock edge
  always #200 osc = ~osc;
  always #400 ext_cnt = ~ext_cnt;
  always @(posedge aclk) begin
    if (ev_clr) ev_seen <= 4'h0;
    else if (aresetn) ev_seen <= ev_seen | ev;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // Only the watchdog ends a wait for the answer
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
  endtask : wr
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    rs = rresp;
  endtask : rdr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] rs;
    rdr(a, d, rs);
    chk(nm, e, d);
  endtask : rdc
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  // ****************
  // Tests
  // ****************
  initial begin
    logic [1:0] rs;
    logic pre;
    cyc(10);
    aresetn <= 1'b1;
    cyc(3);
    chk("oe idle", 32'h0, 32'(wave_oe));
    rdc("mode", ADDR_MODE, 32'h4);
    rdr(8'h24, rd, rs);
    chk("unmapped", 32'(RESP_SLVERR), 32'(rs));
    wr(ADDR_COUNT, 32'h1234);
    rdc("count", ADDR_COUNT, 32'h1234);
    $display("test registers done");
    foreach (rows[i]) begin
      wr(ADDR_CTL1, 32'h10 | 32'(rows[i].src));
      wr(ADDR_CTL2, 32'h0);
      wr(ADDR_COUNT, 32'h0);
      wr(ADDR_WAIT, rows[i].p);
      wr(ADDR_END, rows[i].n);
      wr(ADDR_PERIOD, rows[i].m);
      wr(ADDR_MODE, 32'h1);
      cyc((rows[i].m + 1) * rows[i].sc * 3 + 20);
      chk("high", (rows[i].n - rows[i].p) * rows[i].sc, hi_len);
      chk("period", (rows[i].m + 1) * rows[i].sc, per_len);
      wr(ADDR_MODE, 32'h0);
    end
    chk("oe set", 32'h1, 32'(wave_oe));
    $display("test waveforms done");
    wr(ADDR_CTL1, 32'h18);
    wr(ADDR_MODE, 32'h1);
    cyc(7);
    wr(ADDR_MODE, 32'h0);
    cyc(3);
    chk("stop level", 32'h1, 32'(wave_o));
    rdr(ADDR_COUNT, rd, rs);
    cyc(5);
    rdc("held count", ADDR_COUNT, rd);
    wr(ADDR_CTL1, 32'h0);
    wr(ADDR_CTL2, 32'h4);
    wr(ADDR_COUNT, 32'h0);
    wr(ADDR_WAIT, 32'h3);
    wr(ADDR_END, 32'h6);
    wr(ADDR_PERIOD, 32'h9);
    r0 = rises;
    wr(ADDR_MODE, 32'h1);
    cyc(40);
    chk("one pulse", r0 + 1, rises);
    chk("pulse width", 32'h3, hi_len);
    rdc("stop count", ADDR_COUNT, 32'h9);
    rdc("status", ADDR_STAT, 32'h0);
    wr(ADDR_CTL1, 32'h10);
    wr(ADDR_MODE, 32'h1);
    cyc(40);
    rdc("clear count", ADDR_COUNT, 32'h0);
    $display("test stop done");
    for (int e = 1; e < 4; e++) begin
      pre = (e == 2);
      wr(ADDR_MODE, 32'h0);
      u_far.set_pins(pre, 1'b1);
      wr(ADDR_COUNT, 32'h0);
      wr(ADDR_CTL2, 32'h4 | 32'(e));
      wr(ADDR_MODE, 32'h1);
      r0 = rises;
      cyc(30);
      chk("armed idle", r0, rises);
      u_far.set_pins(!pre, 1'b1);
      cyc(30);
      chk("trigger pulse", r0 + 1, rises);
    end
    $display("test trigger done");
    wr(ADDR_MODE, 32'h0);
    wr(ADDR_CTL2, 32'h8);
    u_far.set_pins(1'b0, 1'b0);
    wr(ADDR_MODE, 32'h1);
    r0 = rises;
    cyc(40);
    chk("cutoff", r0, rises);
    u_far.set_pins(1'b0, 1'b1);
    cyc(40);
    chk("released", 32'h1, 32'(rises > r0));
    wr(ADDR_BUF, 32'h8);
    wr(ADDR_MODE, 32'h3);
    cyc(40);
    chk("buffered width", 32'h5, hi_len);
    wr(ADDR_MODE, 32'h0);
    wr(ADDR_COUNT, 32'hFFF0);
    // Forget events of earlier tests so that each bit must come from this run
    ev_clr <= 1'b1;
    cyc(1);
    ev_clr <= 1'b0;
    wr(ADDR_MODE, 32'h1);
    cyc(30);
    chk("events", 32'hF, 32'(ev_seen));
    $display("test cutoff and events done");
    complete_run();
  end
  // Whole run needs a few thousand cycles; far more means a hang
  initial begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    complete_run();
  end
endmodule : triggered_wait_one_shot_pwm_tb
